//--- pkg/uetc_consts.svh
// Constants for the endpoint 1 / endpoint 2 control block.
// Assumes byte offsets within one aligned AHB-Lite slave window.
`ifndef UETC_CONSTS_SVH
`define UETC_CONSTS_SVH

// ----------------------------------------------------------------
// Register byte offsets (low address byte)
// ----------------------------------------------------------------
`define UETC_OFF_EP1TX   8'h00
`define UETC_OFF_EP2RX   8'h04
`define UETC_OFF_EP2TX   8'h08
`define UETC_OFF_CTRL    8'h0c
`define UETC_OFF_CNT2RX  8'h10
`define UETC_OFF_CNT2TX  8'h14

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define UETC_B_CTR       3
`define UETC_B_DTOG      2
`define UETC_B_STAT_HI   1
`define UETC_B_STAT_LO   0
`define UETC_B_MOD_HI    7
`define UETC_B_MOD_LO    6
`define UETC_B_FORCED_BUS_RESET      0
`define UETC_B_RSV_HI    5
`define UETC_B_RSV_LO    4
`define UETC_CNT_W       7

// ----------------------------------------------------------------
// Encodings and reset values
// ----------------------------------------------------------------
`define UETC_STAT_DIS    2'h0
`define UETC_STAT_STALL  2'h1
`define UETC_STAT_NAK    2'h2
`define UETC_STAT_VALID  2'h3
`define UETC_MOD_NORM    2'h0
`define UETC_MOD_UP      2'h1
`define UETC_MOD_DOWN    2'h2
`define UETC_CNT_RST     7'h00
`define UETC_HTRANS_NSEQ 2'h2
`define UETC_HRESP_OKAY  1'h0

`endif

//--- pkg/uetc_pkg.sv
// Types shared by the endpoint control block and its bench.
// Assumes the USB engine core reports events as one-cycle pulses.
package uetc_pkg;

  // ----------------------------------------------------------------
  // Events from the USB engine and coprocessor path
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       busReset;     // USB reset seen on the bus
    logic       ep1InAck;     // EP1 IN data acknowledged by host
    logic       ep2InAck;     // EP2 IN data acknowledged by host
    logic       ep2OutOk;     // EP2 OUT packet received correctly
    logic       ep2OutPidOk;  // Its data PID matched the expected one
    logic [6:0] ep2OutLen;    // Byte count of that OUT packet
    logic       dlBufReady;   // Coprocessor buffer can take more data
    logic       ulBufReady;   // Coprocessor buffer has more data to send
  } uetc_usb_evt_t;

  // ----------------------------------------------------------------
  // Endpoint control seen by the USB engine
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] ep1TxStat;
    logic       ep1TxToggle;
    logic [1:0] ep2RxStat;
    logic       ep2RxToggle;
    logic [1:0] ep2TxStat;
    logic       ep2TxToggle;
    logic [1:0] ep2Scheme;
    logic       ep1TxDone;
    logic       ep2RxDone;
    logic       ep2TxDone;
    logic       usbReset;
  } uetc_ep_ctl_t;

endpackage

//--- logic/uetc_top.sv
// Control and status registers for EP1 transmit and EP2 receive/transmit,
// with the EP2 hardware-driven bulk upload and download schemes.
// Assumes an AHB-Lite master, and a USB engine giving one-cycle event pulses.
//
// Function
// - USB reset, bus or forced, clears bits 2:0 of endpoint control registers.
// - EP1 transmit-complete flag bit 3 set on good transmission; software clears.
// - Transmit toggle gives next data PID; inverts only after host ACK.
// - Hardware updates toggles on relevant PID; software may also write them.
// - EP1 transmit state 00 off, 01 STALL, 10 NAK, 11 enabled.
// - After correct EP1 transfer hardware forces transmit state to NAK.
// - Bits 7:6 pick EP2 scheme: 00 normal, 01 upload, 10 download.
// - Download handles OUTs in hardware, no interrupt, re-arms VALID when ready.
// - Short packet in download returns normal mode, raises completion, NAKs.
// - Upload handles EP2 INs in hardware like download; OUTs stay normal.
// - Bits 5:4 of EP2 receive control always read zero.
// - EP2 receive-complete flag bit 3 set on good reception; software clears.
// - Receive toggle inverts only on correct packet with matching data PID.
// - EP2 receive state 00 off, 01 STALL, 10 NAK, 11 enabled.
// - After correct EP2 transfer in normal mode receive state forced to NAK.
// - Writes to EP2 receive state ignored while scheme is download.
// - Writes to EP2 transmit state ignored while scheme is upload.
`timescale 1ns/1ps
`include "uetc_consts.svh"

module uetc_top (
  input  wire logic                   core_clk,
  input  wire logic                   rst,
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [31:0]            hwdata,
  input  wire logic                   hready,
  output logic [31:0]                 hrdata,
  output logic                        hreadyout,
  output logic                        hresp,
  input  wire uetc_pkg::uetc_usb_evt_t usbEvt,
  output uetc_pkg::uetc_ep_ctl_t       epCtl
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic                   ep1Ctr_q;
  logic                   ep1Dtog_q;
  logic [1:0]             ep1Stat_q;
  logic [1:0]             ep2Mod_q;
  logic                   ep2RxCtr_q;
  logic                   ep2RxDtog_q;
  logic [1:0]             ep2RxStat_q;
  logic                   ep2TxCtr_q;
  logic                   ep2TxDtog_q;
  logic [1:0]             ep2TxStat_q;
  logic                   forced_bus_reset_q;
  logic [`UETC_CNT_W-1:0] rxMax_q;
  logic [`UETC_CNT_W-1:0] txMax_q;
  logic                   busRst_q;

  // Bus pipeline state
  logic                   wrPend_q;
  logic [7:0]             wrAddr_q;
  logic [31:0]            rdData_d;
  logic [31:0]            rdData_q;

  // Decoded strobes and conditions
  logic                   addrPhase;
  logic                   wrEp1;
  logic                   wrEp2Rx;
  logic                   wrEp2Tx;
  logic                   wrCtrl;
  logic                   wrCnt2Rx;
  logic                   wrCnt2Tx;
  logic                   usbRst;
  logic                   modeDown;
  logic                   modeUp;
  logic                   shortPkt;
  logic                   dlFull;
  logic                   ulInAck;

  // ----------------------------------------------------------------
  // AHB-Lite address phase capture
  // ----------------------------------------------------------------
  assign addrPhase = hsel && hready && htrans[1];

  // Writes land in the data phase, when hwdata is on the bus
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wrPend_q <= 1'b0;
      wrAddr_q <= 8'h00;
    end else if (hready) begin
      wrPend_q <= addrPhase && hwrite;
      wrAddr_q <= haddr[7:0];
    end
  end

  // Write strobes; unmapped offsets simply match nothing
  always_comb begin
    wrEp1    = 1'b0;
    wrEp2Rx  = 1'b0;
    wrEp2Tx  = 1'b0;
    wrCtrl   = 1'b0;
    wrCnt2Rx = 1'b0;
    wrCnt2Tx = 1'b0;
    if (wrPend_q && wrAddr_q == `UETC_OFF_EP1TX) begin
      wrEp1 = 1'b1;
    end else if (wrPend_q && wrAddr_q == `UETC_OFF_EP2RX) begin
      wrEp2Rx = 1'b1;
    end else if (wrPend_q && wrAddr_q == `UETC_OFF_EP2TX) begin
      wrEp2Tx = 1'b1;
    end else if (wrPend_q && wrAddr_q == `UETC_OFF_CTRL) begin
      wrCtrl = 1'b1;
    end else if (wrPend_q && wrAddr_q == `UETC_OFF_CNT2RX) begin
      wrCnt2Rx = 1'b1;
    end else if (wrPend_q && wrAddr_q == `UETC_OFF_CNT2TX) begin
      wrCnt2Tx = 1'b1;
    end
  end

  // Read mux, sampled at the address phase for a zero-wait answer
  always_comb begin
    rdData_d = 32'h0000_0000;
    if (haddr[7:0] == `UETC_OFF_EP1TX) begin
      rdData_d[`UETC_B_CTR]  = ep1Ctr_q;
      rdData_d[`UETC_B_DTOG] = ep1Dtog_q;
      rdData_d[`UETC_B_STAT_HI:`UETC_B_STAT_LO] = ep1Stat_q;
    end else if (haddr[7:0] == `UETC_OFF_EP2RX) begin
      rdData_d[`UETC_B_MOD_HI:`UETC_B_MOD_LO]   = ep2Mod_q;
      rdData_d[`UETC_B_RSV_HI:`UETC_B_RSV_LO]   = 2'h0;
      rdData_d[`UETC_B_CTR]  = ep2RxCtr_q;
      rdData_d[`UETC_B_DTOG] = ep2RxDtog_q;
      rdData_d[`UETC_B_STAT_HI:`UETC_B_STAT_LO] = ep2RxStat_q;
    end else if (haddr[7:0] == `UETC_OFF_EP2TX) begin
      rdData_d[`UETC_B_CTR]  = ep2TxCtr_q;
      rdData_d[`UETC_B_DTOG] = ep2TxDtog_q;
      rdData_d[`UETC_B_STAT_HI:`UETC_B_STAT_LO] = ep2TxStat_q;
    end else if (haddr[7:0] == `UETC_OFF_CTRL) begin
      rdData_d[`UETC_B_FORCED_BUS_RESET] = forced_bus_reset_q;
    end else if (haddr[7:0] == `UETC_OFF_CNT2RX) begin
      rdData_d[`UETC_CNT_W-1:0] = rxMax_q;
    end else if (haddr[7:0] == `UETC_OFF_CNT2TX) begin
      rdData_d[`UETC_CNT_W-1:0] = txMax_q;
    end
  end

  // Read data register; a read right after a write sees the old value
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rdData_q <= 32'h0000_0000;
    end else if (addrPhase && !hwrite) begin
      rdData_q <= rdData_d;
    end
  end

  // Never stalls and never errors
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      hreadyout <= 1'b1;
      hresp     <= `UETC_HRESP_OKAY;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= `UETC_HRESP_OKAY;
    end
  end

  assign hrdata = rdData_q;

  // ----------------------------------------------------------------
  // USB reset and mode decode
  // ----------------------------------------------------------------
  // Forced reset bit is held by software until it clears it
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      forced_bus_reset_q <= 1'b0;
    end else if (wrCtrl) begin
      forced_bus_reset_q <= hwdata[`UETC_B_FORCED_BUS_RESET];
    end
  end

  // Registered so the engine sees a clean level
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      busRst_q <= 1'b0;
    end else begin
      busRst_q <= usbEvt.busReset || forced_bus_reset_q;
    end
  end

  assign usbRst   = usbEvt.busReset || forced_bus_reset_q;
  assign modeDown = (ep2Mod_q == `UETC_MOD_DOWN);
  assign modeUp   = (ep2Mod_q == `UETC_MOD_UP);
  assign shortPkt = (usbEvt.ep2OutLen < rxMax_q);
  assign dlFull   = usbEvt.ep2OutOk && modeDown && !shortPkt;
  assign ulInAck  = usbEvt.ep2InAck && modeUp;

  // ----------------------------------------------------------------
  // Maximum packet size registers
  // ----------------------------------------------------------------
  // Software loads these before entering a hardware scheme
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rxMax_q <= `UETC_CNT_RST;
      txMax_q <= `UETC_CNT_RST;
    end else begin
      if (wrCnt2Rx) begin
        rxMax_q <= hwdata[`UETC_CNT_W-1:0];
      end
      if (wrCnt2Tx) begin
        txMax_q <= hwdata[`UETC_CNT_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Endpoint 1 transmit control
  // ----------------------------------------------------------------
  // Completion flag: hardware set wins over a write of zero
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ep1Ctr_q <= 1'b0;
    end else if (usbEvt.ep1InAck) begin
      ep1Ctr_q <= 1'b1;
    end else if (wrEp1 && !hwdata[`UETC_B_CTR]) begin
      ep1Ctr_q <= 1'b0;
    end
  end

  // Toggle and state; hardware update beats a same-cycle write
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ep1Dtog_q <= 1'b0;
      ep1Stat_q <= `UETC_STAT_DIS;
    end else if (usbRst) begin
      ep1Dtog_q <= 1'b0;
      ep1Stat_q <= `UETC_STAT_DIS;
    end else if (usbEvt.ep1InAck) begin
      ep1Dtog_q <= ~ep1Dtog_q;
      ep1Stat_q <= `UETC_STAT_NAK;
    end else if (wrEp1) begin
      ep1Dtog_q <= hwdata[`UETC_B_DTOG];
      ep1Stat_q <= hwdata[`UETC_B_STAT_HI:`UETC_B_STAT_LO];
    end
  end

  // ----------------------------------------------------------------
  // Endpoint 2 scheme select
  // ----------------------------------------------------------------
  // A short download packet hands control back to software
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ep2Mod_q <= `UETC_MOD_NORM;
    end else if (usbEvt.ep2OutOk && modeDown && shortPkt) begin
      ep2Mod_q <= `UETC_MOD_NORM;
    end else if (wrEp2Rx) begin
      ep2Mod_q <= hwdata[`UETC_B_MOD_HI:`UETC_B_MOD_LO];
    end
  end

  // ----------------------------------------------------------------
  // Endpoint 2 receive control
  // ----------------------------------------------------------------
  // Full download packets stay silent; short ones and normal ones flag
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ep2RxCtr_q <= 1'b0;
    end else if (usbEvt.ep2OutOk && !dlFull) begin
      ep2RxCtr_q <= 1'b1;
    end else if (wrEp2Rx && !hwdata[`UETC_B_CTR]) begin
      ep2RxCtr_q <= 1'b0;
    end
  end

  // Expected data PID for the next OUT
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ep2RxDtog_q <= 1'b0;
    end else if (usbRst) begin
      ep2RxDtog_q <= 1'b0;
    end else if (usbEvt.ep2OutOk && usbEvt.ep2OutPidOk) begin
      ep2RxDtog_q <= ~ep2RxDtog_q;
    end else if (wrEp2Rx) begin
      ep2RxDtog_q <= hwdata[`UETC_B_DTOG];
    end
  end

  // Receive state; download re-arms from NAK once the buffer has room
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ep2RxStat_q <= `UETC_STAT_DIS;
    end else if (usbRst) begin
      ep2RxStat_q <= `UETC_STAT_DIS;
    end else if (dlFull) begin
      ep2RxStat_q <= usbEvt.dlBufReady ? `UETC_STAT_VALID : `UETC_STAT_NAK;
    end else if (usbEvt.ep2OutOk) begin
      ep2RxStat_q <= `UETC_STAT_NAK;
    end else if (modeDown && ep2RxStat_q == `UETC_STAT_NAK && usbEvt.dlBufReady) begin
      ep2RxStat_q <= `UETC_STAT_VALID;
    end else if (wrEp2Rx && !modeDown) begin
      ep2RxStat_q <= hwdata[`UETC_B_STAT_HI:`UETC_B_STAT_LO];
    end
  end

  // ----------------------------------------------------------------
  // Endpoint 2 transmit control
  // ----------------------------------------------------------------
  // Upload mode acknowledges INs without a per-packet flag
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ep2TxCtr_q <= 1'b0;
    end else if (usbEvt.ep2InAck && !modeUp) begin
      ep2TxCtr_q <= 1'b1;
    end else if (wrEp2Tx && !hwdata[`UETC_B_CTR]) begin
      ep2TxCtr_q <= 1'b0;
    end
  end

  // Transmit toggle flips on each acknowledged IN
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ep2TxDtog_q <= 1'b0;
    end else if (usbRst) begin
      ep2TxDtog_q <= 1'b0;
    end else if (usbEvt.ep2InAck) begin
      ep2TxDtog_q <= ~ep2TxDtog_q;
    end else if (wrEp2Tx) begin
      ep2TxDtog_q <= hwdata[`UETC_B_DTOG];
    end
  end

  // Transmit state; upload re-arms when the coprocessor has data
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ep2TxStat_q <= `UETC_STAT_DIS;
    end else if (usbRst) begin
      ep2TxStat_q <= `UETC_STAT_DIS;
    end else if (ulInAck) begin
      ep2TxStat_q <= usbEvt.ulBufReady ? `UETC_STAT_VALID : `UETC_STAT_NAK;
    end else if (usbEvt.ep2InAck) begin
      ep2TxStat_q <= `UETC_STAT_NAK;
    end else if (modeUp && ep2TxStat_q == `UETC_STAT_NAK && usbEvt.ulBufReady) begin
      ep2TxStat_q <= `UETC_STAT_VALID;
    end else if (wrEp2Tx && !modeUp) begin
      ep2TxStat_q <= hwdata[`UETC_B_STAT_HI:`UETC_B_STAT_LO];
    end
  end

  // ----------------------------------------------------------------
  // Engine-side outputs, all straight from flip-flops
  // ----------------------------------------------------------------
  assign epCtl.ep1TxStat   = ep1Stat_q;
  assign epCtl.ep1TxToggle = ep1Dtog_q;
  assign epCtl.ep2RxStat   = ep2RxStat_q;
  assign epCtl.ep2RxToggle = ep2RxDtog_q;
  assign epCtl.ep2TxStat   = ep2TxStat_q;
  assign epCtl.ep2TxToggle = ep2TxDtog_q;
  assign epCtl.ep2Scheme   = ep2Mod_q;
  assign epCtl.ep1TxDone   = ep1Ctr_q;
  assign epCtl.ep2RxDone   = ep2RxCtr_q;
  assign epCtl.ep2TxDone   = ep2TxCtr_q;
  assign epCtl.usbReset    = busRst_q;

  // hsize is accepted but only whole-word transfers are supported
  logic unusedHsize;
  assign unusedHsize = ^hsize;

endmodule

//--- tb/uetc_top_properties.sv
// Concurrent checks on the endpoint control block's ports.
// Assumes a single clock domain and one-cycle USB event pulses.
`timescale 1ns/1ps
`include "uetc_consts.svh"

module uetc_top_properties (
  input wire logic                    core_clk,
  input wire logic                    rst,
  input wire logic                    hsel,
  input wire logic [1:0]              htrans,
  input wire logic                    hwrite,
  input wire uetc_pkg::uetc_usb_evt_t usbEvt,
  input wire uetc_pkg::uetc_ep_ctl_t  epCtl
);
  // ----------------------------------------------------------------
  // Endpoint state checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  usb_reset_clr_a: assert property (
    usbEvt.busReset |=> epCtl.usbReset && epCtl.ep1TxStat == 2'h0 && !epCtl.ep1TxToggle
      && epCtl.ep2RxStat == 2'h0 && !epCtl.ep2RxToggle && epCtl.ep2TxStat == 2'h0)
    else $error("USB reset left endpoint state bits set");
  ep1_ack_flags_a: assert property (
    usbEvt.ep1InAck && !usbEvt.busReset |=> epCtl.ep1TxDone
      && epCtl.ep1TxStat == `UETC_STAT_NAK)
    else $error("EP1 ack did not set done and NAK");
  ep1_ack_toggle_a: assert property (
    usbEvt.ep1InAck && !usbEvt.busReset |=> epCtl.ep1TxToggle != $past(epCtl.ep1TxToggle))
    else $error("EP1 toggle did not invert on ack");
  // The EP1 transmit toggle may only move for an ack, a bus write or a USB reset
  tx_toggle_cause_a: assert property (
    $changed(epCtl.ep1TxToggle) |-> $past(usbEvt.ep1InAck) || epCtl.usbReset
      || $past(hsel && htrans[1] && hwrite, 2))
    else $error("EP1 toggle changed without cause");
  ep2_out_normal_a: assert property (
    usbEvt.ep2OutOk && !usbEvt.busReset && epCtl.ep2Scheme != `UETC_MOD_DOWN
      |=> epCtl.ep2RxDone && epCtl.ep2RxStat == `UETC_STAT_NAK)
    else $error("EP2 reception did not complete with NAK");
  ep2_rx_toggle_a: assert property (
    usbEvt.ep2OutOk && !usbEvt.busReset |=> epCtl.ep2RxToggle
      == ($past(epCtl.ep2RxToggle) ^ $past(usbEvt.ep2OutPidOk)))
    else $error("EP2 receive toggle wrong after packet");
  dl_out_result_a: assert property (
    usbEvt.ep2OutOk && !usbEvt.busReset && epCtl.ep2Scheme == `UETC_MOD_DOWN
      |=> (epCtl.ep2Scheme == `UETC_MOD_DOWN && !$rose(epCtl.ep2RxDone)
        && epCtl.ep2RxStat == ($past(usbEvt.dlBufReady) ? 2'h3 : 2'h2))
      || (epCtl.ep2Scheme == `UETC_MOD_NORM && epCtl.ep2RxDone && epCtl.ep2RxStat == 2'h2))
    else $error("Download packet handled wrongly");
  dl_rearm_a: assert property (
    epCtl.ep2Scheme == `UETC_MOD_DOWN && epCtl.ep2RxStat == `UETC_STAT_NAK
      && usbEvt.dlBufReady && !usbEvt.ep2OutOk && !usbEvt.busReset
      |=> epCtl.ep2RxStat == `UETC_STAT_VALID)
    else $error("Download did not re-arm reception");
  ul_in_result_a: assert property (
    usbEvt.ep2InAck && !usbEvt.busReset && epCtl.ep2Scheme == `UETC_MOD_UP
      |=> epCtl.ep2TxToggle != $past(epCtl.ep2TxToggle) && !$rose(epCtl.ep2TxDone)
        && epCtl.ep2TxStat == ($past(usbEvt.ulBufReady) ? 2'h3 : 2'h2))
    else $error("Upload IN handled wrongly");

  // Main scenarios reached
  cover property (usbEvt.ep1InAck);
  cover property (epCtl.ep2Scheme == `UETC_MOD_DOWN ##1 epCtl.ep2Scheme == `UETC_MOD_NORM);
  cover property (usbEvt.ep2InAck && epCtl.ep2Scheme == `UETC_MOD_UP);
endmodule

bind uetc_top uetc_top_properties props (
  .core_clk(core_clk), .rst(rst), .hsel(hsel), .htrans(htrans),
  .hwrite(hwrite), .usbEvt(usbEvt), .epCtl(epCtl));

//--- tb/uetc_host_model.sv
// Far-side model: USB engine events as seen from the host's traffic.
// Assumes tasks are called just after a rising clock edge.
`timescale 1ns/1ps

module uetc_host_model (
  input  wire logic               core_clk,
  output uetc_pkg::uetc_usb_evt_t usbEvt
);
  // ----------------------------------------------------------------
  // Event pulses and buffer levels
  // ----------------------------------------------------------------
  initial usbEvt = '0;

  // One-cycle pulse; 0 bus reset, 1 EP1 ack, 2 EP2 ack, else EP2 OUT
  task automatic pulse(input int k, input logic [6:0] len, input logic pid);
    @(posedge core_clk);
    case (k)
      0: usbEvt.busReset <= 1'b1;
      1: usbEvt.ep1InAck <= 1'b1;
      2: usbEvt.ep2InAck <= 1'b1;
      default: usbEvt.ep2OutOk <= 1'b1;
    endcase
    usbEvt.ep2OutLen <= len;
    usbEvt.ep2OutPidOk <= pid;
    @(posedge core_clk);
    {usbEvt.busReset, usbEvt.ep1InAck, usbEvt.ep2InAck, usbEvt.ep2OutOk} <= 4'h0;
    usbEvt.ep2OutLen <= ~len; // Stale length never reads as the last one
    usbEvt.ep2OutPidOk <= ~pid;
  endtask

  // Coprocessor buffer levels
  task automatic bufs(input logic dl, input logic ul);
    @(posedge core_clk);
    usbEvt.dlBufReady <= dl;
    usbEvt.ulBufReady <= ul;
  endtask
endmodule

//--- tb/usb_endpoint_tx_rx_ctrl_tb.sv
// Register-level bench for the endpoint control block.
// Assumes AHB-Lite single word transfers and the host model's events.
`timescale 1ns/1ps
`include "uetc_consts.svh"

module usb_endpoint_tx_rx_ctrl_tb;
  localparam logic [7:0] aTx1 = `UETC_OFF_EP1TX;
  localparam logic [7:0] aRx2 = `UETC_OFF_EP2RX;
  localparam logic [7:0] aTx2 = `UETC_OFF_EP2TX;
  localparam logic [7:0] aCtl = `UETC_OFF_CTRL;
  logic                    core_clk;
  logic                    rst;
  logic                    hsel;
  logic                    hwrite;
  logic                    hreadyout;
  logic                    hresp;
  logic [1:0]              htrans;
  logic [31:0]             haddr;
  logic [31:0]             hwdata;
  logic [31:0]             hrdata;
  logic [31:0]             rdv;
  int                      badCount;
  int                      samplesChecked;
  uetc_pkg::uetc_usb_evt_t usbEvt;
  uetc_pkg::uetc_ep_ctl_t  epCtl;

  uetc_top uut (
    .core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .usbEvt(usbEvt),
    .epCtl(epCtl));
  uetc_host_model host (.core_clk(core_clk), .usbEvt(usbEvt));

  // ----------------------------------------------------------------
  // Clock and helpers
  // ----------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  task automatic closeOut();
    $display("checks %0d mismatches %0d", samplesChecked, badCount);
    if (badCount == 0 && samplesChecked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samplesChecked++;
    if (got !== exp) begin
      badCount++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Bounded wait for ready at a rising edge; a hang ends the run
  task automatic waitRdy();
    int n;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 16);
    if (hreadyout !== 1'b1) begin
      badCount++;
      $display("FAIL hreadyout expected 1 seen %b", hreadyout);
      closeOut();
    end
  endtask

  // One single transfer; the leading edge keeps a cycle between accesses
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= `UETC_HTRANS_NSEQ;
    hwrite <= w;
    waitRdy();
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    waitRdy();
    rdv = hrdata;
    chk("hresp", 32'h0, 32'(hresp)); // Slave must always answer OKAY
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
    bus(1'b0, a, 8'h00);
    chk(nm, {24'h0, e}, rdv);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    badCount = 0;
    samplesChecked = 0;
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    rd(aTx1, 8'h00, "ep1 tx reset");
    rd(aRx2, 8'h00, "ep2 rx reset");
    rd(aTx2, 8'h00, "ep2 tx reset");
    rd(8'h1c, 8'h00, "unmapped");
    // Every state code on both endpoints
    for (int s = 0; s < 4; s++) begin
      wr(aTx1, 8'(s));
      wr(aRx2, 8'(s));
      rd(aTx1, 8'(s), "ep1 state");
      chk("ep1 stat pin", 32'(s), 32'(epCtl.ep1TxStat));
      rd(aRx2, 8'(s), "ep2 rx state");
      chk("ep2 stat pin", 32'(s), 32'(epCtl.ep2RxStat));
    end
    wr(aRx2, 8'h3c);
    rd(aRx2, 8'h04, "ep2 rx reserved");
    // EP1 transmission completes
    wr(aTx1, 8'h03);
    host.pulse(1, 7'h00, 1'b0);
    rd(aTx1, 8'h0e, "ep1 after ack");
    wr(aTx1, 8'h03);
    rd(aTx1, 8'h03, "ep1 rearmed");
    // EP2 normal reception, bad PID, scheme 11
    wr(aRx2, 8'h03);
    host.pulse(3, 7'h08, 1'b1);
    rd(aRx2, 8'h0e, "ep2 rx good");
    wr(aRx2, 8'h07);
    host.pulse(3, 7'h08, 1'b0);
    rd(aRx2, 8'h0e, "ep2 rx pid bad");
    wr(aRx2, 8'hc3);
    host.pulse(3, 7'h08, 1'b1);
    rd(aRx2, 8'hce, "scheme 11");
    // Download: full packet, locked state, re-arm, short exit
    wr(`UETC_OFF_CNT2RX, 8'h40);
    wr(aRx2, 8'h03);
    wr(aRx2, 8'h83);
    #1 chk("scheme pin", 32'h2, 32'(epCtl.ep2Scheme));
    host.pulse(3, 7'h40, 1'b1);
    rd(aRx2, 8'h86, "download full");
    wr(aRx2, 8'h84);
    rd(aRx2, 8'h86, "download locked");
    host.bufs(1'b1, 1'b0);
    rd(aRx2, 8'h87, "download rearm");
    host.pulse(3, 7'h0a, 1'b1);
    rd(aRx2, 8'h0a, "download short");
    // Upload: IN in hardware, locked state, OUT as normal
    host.bufs(1'b0, 1'b1);
    wr(`UETC_OFF_CNT2TX, 8'h40);
    wr(aTx2, 8'h02);
    wr(aRx2, 8'h40);
    host.pulse(2, 7'h00, 1'b0);
    rd(aTx2, 8'h07, "upload in");
    wr(aTx2, 8'h04);
    rd(aTx2, 8'h07, "upload locked");
    host.pulse(3, 7'h08, 1'b1);
    rd(aRx2, 8'h4e, "upload out");
    // USB reset from the bus, then forced by software
    wr(aTx1, 8'h07);
    host.pulse(0, 7'h00, 1'b0);
    rd(aTx1, 8'h00, "bus reset ep1");
    rd(aRx2, 8'h48, "bus reset ep2 rx");
    rd(aTx2, 8'h00, "bus reset ep2 tx");
    wr(aCtl, 8'h01);
    wr(aTx1, 8'h07);
    rd(aTx1, 8'h00, "forced reset");
    chk("usb reset pin", 32'h1, 32'(epCtl.usbReset));
    wr(aCtl, 8'h00);
    wr(aTx1, 8'h07);
    rd(aTx1, 8'h07, "reset released");
    closeOut();
  end

  // Hang guard, far beyond the sequence length
  initial begin
    repeat (20000) @(posedge core_clk);
    badCount++;
    $display("FAIL run length expected under 20000 seen 20000");
    closeOut();
  end
endmodule
